/* core/trig_qual_pkg.sv */
/*
 Package for the trigger qualifier: register offsets, field codes, reset values and enumerations.
 Assumes a single 100 MHz sample clock and a plain register port.
*/
package trig_qual_pkg;
   localparam int ADDR_W = 5;
   localparam int SMP_W = 12;
   localparam int CNT_W = 24;
   localparam int LINE_W = 11;
   localparam int NCH = 4;
   localparam int CLK_MHZ = 100;
   localparam int CH_SEL_W = 3;

   // Register offsets (word index)
   localparam logic [ADDR_W-1:0] CTRL_OFF = 5'h00;
   localparam logic [ADDR_W-1:0] A_CFG_OFF = 5'h01;
   localparam logic [ADDR_W-1:0] B_CFG_OFF = 5'h02;
   localparam logic [ADDR_W-1:0] B_DELAY_OFF = 5'h03;
   localparam logic [ADDR_W-1:0] W_CFG_OFF = 5'h04;
   localparam logic [ADDR_W-1:0] W_REF_OFF = 5'h05;
   localparam logic [ADDR_W-1:0] W_TOL_OFF = 5'h06;
   localparam logic [ADDR_W-1:0] W_LOW_OFF = 5'h07;
   localparam logic [ADDR_W-1:0] W_HIGH_OFF = 5'h08;
   localparam logic [ADDR_W-1:0] V_CFG_OFF = 5'h09;
   localparam logic [ADDR_W-1:0] L_CFG_OFF = 5'h0A;
   localparam logic [ADDR_W-1:0] L_TIME_OFF = 5'h0B;
   localparam logic [ADDR_W-1:0] STATUS_OFF = 5'h0C;
   localparam logic [ADDR_W-1:0] W_LAST_OFF = 5'h0D;
   localparam logic [ADDR_W-1:0] V_LINE_OFF = 5'h0E;

   // CTRL fields
   localparam int CTRL_TYPE_LSB = 0;
   localparam int CTRL_NOISE_BIT = 4;
   localparam int CTRL_HFF_BIT = 5;
   localparam int CTRL_BDLY_EV_BIT = 6;
   localparam int CTRL_ARM_BIT = 7;
   // Stage config fields: source, edge, hysteresis, level
   localparam int ST_SRC_LSB = 0;
   localparam int ST_EDGE_LSB = 4;
   localparam int ST_HYS_LSB = 8;
   localparam int ST_LVL_LSB = 16;
   localparam int HYS_W = 8;
   localparam logic [SMP_W-1:0] NOISE_EXTRA_HYS = 12'h040;
   localparam logic [CH_SEL_W-1:0] SRC_EXT = 3'h4;

   typedef enum logic [2:0] {
      TT_EDGE = 3'b000, TT_EDGE_AB = 3'b001, TT_WIDTH = 3'b010,
      TT_VIDEO = 3'b011, TT_LOGIC = 3'b100
   } trig_type_t;

   typedef enum logic [1:0] {
      EDGE_RISE = 2'b00, EDGE_FALL = 2'b01, EDGE_BOTH = 2'b10
   } edge_sel_t;

   typedef enum logic [2:0] {
      CMP_GT = 3'b000, CMP_LT = 3'b001, CMP_EQ = 3'b010,
      CMP_NE = 3'b011, CMP_IN = 3'b100, CMP_OUT = 3'b101
   } cmp_mode_t;

   typedef enum logic [2:0] {
      VM_ALL_FRAMES = 3'b000, VM_ODD_FRAMES = 3'b001, VM_EVEN_FRAMES = 3'b010,
      VM_ALL_LINES = 3'b011, VM_LINE_NUM = 3'b100
   } video_mode_t;

   typedef enum logic [2:0] {
      VS_PAL = 3'b000, VS_NTSC = 3'b001, VS_SECAM = 3'b010, VS_PAL_M = 3'b011,
      VS_576I = 3'b100, VS_720P = 3'b101, VS_1080P = 3'b110, VS_1080I = 3'b111
   } video_std_t;

   typedef enum logic [1:0] {
      SEQ_WAIT_A = 2'b00, SEQ_DELAY = 2'b01, SEQ_WAIT_B = 2'b10
   } seq_state_t;

   // Sync longer than this many microseconds marks a vertical (field) pulse
   localparam int VSYNC_US = 10;
   localparam logic [CNT_W-1:0] VSYNC_CYC = CNT_W'(VSYNC_US * CLK_MHZ);
   localparam logic [LINE_W-1:0] LINE_FIRST = 11'h001;
endpackage : trig_qual_pkg

/* core/trigger_qualifier_unit.sv */
/*
 Trigger qualifier: edge, edge A/B sequence, pulse width, video sync and logic triggers.
 Assumes sampled channels synchronous to clk and a plain register port with one-cycle read latency.
*/
// The address map and the strobed register port were left to the implementer.
// What this block does
// - Noise reject widens hysteresis around level
// - Sequence triggers after A then B
// - B ignored until an A event
// - B has own source, level, edge, hysteresis
// - Wait configured delay after A
// - Time delay: check B after duration
// - Event delay: fire on n-th B event
// - Width measured between threshold crossings
// - Positive: rise to fall; negative: fall to rise
// - Greater-than fires above reference
// - Less-than fires below reference
// - Equal: exact, or within tolerance window
// - Unequal: different, or outside tolerance window
// - Inside and outside limit comparisons
// - Limit pair and reference pair stay consistent
// - Video fires on sync pulse trailing edges
// - Sync polarity opposite to modulation
// - Mode selects frames, odd, even, lines, line
// - Line mode fires at programmed line
// - SD standards plus 720p, 1080p, 1080i
// - Logic combination with optional time limit
`timescale 1ns/1ps
module trigger_qualifier_unit #(
   parameter int SMP_W = trig_qual_pkg::SMP_W,
   parameter int NCH = trig_qual_pkg::NCH,
   parameter int CNT_W = trig_qual_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NCH*SMP_W-1:0] ch_samples,
   input wire logic [SMP_W-1:0] ext_sample,
   input wire logic [trig_qual_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic trigger_pulse,
   output logic high_freq_filter_enable
);
   localparam int LW = trig_qual_pkg::LINE_W;

   logic [2:0] type_reg;
   logic noise_reg;
   logic hff_reg;
   logic bdly_ev_reg;
   logic arm_reg;
   logic [31:0] a_cfg_reg;
   logic [31:0] b_cfg_reg;
   logic [CNT_W-1:0] b_delay_reg;
   logic [3:0] w_cfg_reg;
   logic [CNT_W-1:0] w_ref_reg;
   logic [CNT_W-1:0] w_tol_reg;
   logic [CNT_W-1:0] w_low_reg;
   logic [CNT_W-1:0] w_high_reg;
   logic [7:0] v_cfg_reg;
   logic [LW-1:0] v_line_cfg_reg;
   logic [15:0] l_cfg_reg;
   logic [CNT_W-1:0] l_time_reg;
   logic [CNT_W-1:0] w_last_reg;
   logic [7:0] trig_count_reg;

   // Selects one channel sample
   function automatic logic [SMP_W-1:0] pick(input logic [2:0] sel,
                                             input logic [NCH*SMP_W-1:0] ch,
                                             input logic [SMP_W-1:0] ext);
      logic [SMP_W-1:0] r;
      r = ext;
      if (sel < 3'(NCH)) begin
         r = ch[sel*SMP_W +: SMP_W];
      end
      return r;
   endfunction : pick

   // Hysteresis comparator next state
   function automatic logic hys_next(input logic cur, input logic [SMP_W-1:0] s,
                                     input logic [SMP_W-1:0] lvl,
                                     input logic [SMP_W-1:0] h);
      logic r;
      r = cur;
      if ({1'b0, s} > {1'b0, lvl} + {1'b0, h}) begin
         r = 1'b1;
      end else if ({1'b0, s} + {1'b0, h} < {1'b0, lvl}) begin
         r = 1'b0;
      end
      return r;
   endfunction : hys_next

   function automatic logic edge_hit(input logic prev, input logic cur,
                                     input logic [1:0] sel);
      logic r;
      r = 1'b0;
      unique case (sel)
         trig_qual_pkg::EDGE_RISE: r = !prev && cur;
         trig_qual_pkg::EDGE_FALL: r = prev && !cur;
         default: r = prev != cur;
      endcase
      return r;
   endfunction : edge_hit

   // Register writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         type_reg <= trig_qual_pkg::TT_EDGE;
         noise_reg <= 1'b0;
         hff_reg <= 1'b0;
         bdly_ev_reg <= 1'b0;
         arm_reg <= 1'b0;
         a_cfg_reg <= 32'h0800_0000;
         b_cfg_reg <= 32'h0800_0000;
         b_delay_reg <= '0;
         w_cfg_reg <= 4'h0;
         w_ref_reg <= '0;
         w_tol_reg <= '0;
         w_low_reg <= '0;
         w_high_reg <= '0;
         v_cfg_reg <= 8'h00;
         v_line_cfg_reg <= trig_qual_pkg::LINE_FIRST;
         l_cfg_reg <= 16'h0000;
         l_time_reg <= '0;
      end else if (reg_write) begin
         unique case (reg_addr)
            trig_qual_pkg::CTRL_OFF: begin
               type_reg <= reg_wdata[trig_qual_pkg::CTRL_TYPE_LSB +: 3];
               bdly_ev_reg <= reg_wdata[trig_qual_pkg::CTRL_BDLY_EV_BIT];
               arm_reg <= reg_wdata[trig_qual_pkg::CTRL_ARM_BIT];
               noise_reg <= reg_wdata[trig_qual_pkg::CTRL_NOISE_BIT];
               hff_reg <= reg_wdata[trig_qual_pkg::CTRL_HFF_BIT]
                  && !reg_wdata[trig_qual_pkg::CTRL_NOISE_BIT];
            end
            trig_qual_pkg::A_CFG_OFF: a_cfg_reg <= reg_wdata;
            trig_qual_pkg::B_CFG_OFF: b_cfg_reg <= reg_wdata;
            trig_qual_pkg::B_DELAY_OFF: b_delay_reg <= reg_wdata[CNT_W-1:0];
            trig_qual_pkg::W_CFG_OFF: w_cfg_reg <= reg_wdata[3:0];
            trig_qual_pkg::W_REF_OFF: begin
               w_ref_reg <= reg_wdata[CNT_W-1:0];
               w_low_reg <= reg_wdata[CNT_W-1:0] - w_tol_reg;
               w_high_reg <= reg_wdata[CNT_W-1:0] + w_tol_reg;
            end
            trig_qual_pkg::W_TOL_OFF: begin
               w_tol_reg <= reg_wdata[CNT_W-1:0];
               w_low_reg <= w_ref_reg - reg_wdata[CNT_W-1:0];
               w_high_reg <= w_ref_reg + reg_wdata[CNT_W-1:0];
            end
            trig_qual_pkg::W_LOW_OFF: begin
               w_low_reg <= reg_wdata[CNT_W-1:0];
               w_ref_reg <= CNT_W'((w_high_reg + reg_wdata[CNT_W-1:0]) >> 1);
               w_tol_reg <= CNT_W'((w_high_reg - reg_wdata[CNT_W-1:0]) >> 1);
            end
            trig_qual_pkg::W_HIGH_OFF: begin
               w_high_reg <= reg_wdata[CNT_W-1:0];
               w_ref_reg <= CNT_W'((reg_wdata[CNT_W-1:0] + w_low_reg) >> 1);
               w_tol_reg <= CNT_W'((reg_wdata[CNT_W-1:0] - w_low_reg) >> 1);
            end
            trig_qual_pkg::V_CFG_OFF: v_cfg_reg <= reg_wdata[7:0];
            trig_qual_pkg::V_LINE_OFF: v_line_cfg_reg <= reg_wdata[LW-1:0];
            trig_qual_pkg::L_CFG_OFF: l_cfg_reg <= reg_wdata[15:0];
            trig_qual_pkg::L_TIME_OFF: l_time_reg <= reg_wdata[CNT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   assign high_freq_filter_enable = hff_reg;

   // Comparators for stage A and B with noise widening
   logic [SMP_W-1:0] a_hys;
   logic [SMP_W-1:0] b_hys;
   logic [SMP_W-1:0] a_smp;
   logic [SMP_W-1:0] b_smp;
   logic a_lvl_reg;
   logic b_lvl_reg;
   logic a_prev_reg;
   logic b_prev_reg;
   logic a_ev;
   logic b_ev;

   always_comb begin
      a_hys = SMP_W'(a_cfg_reg[trig_qual_pkg::ST_HYS_LSB +: trig_qual_pkg::HYS_W]);
      b_hys = SMP_W'(b_cfg_reg[trig_qual_pkg::ST_HYS_LSB +: trig_qual_pkg::HYS_W]);
      if (noise_reg) begin
         a_hys = a_hys + trig_qual_pkg::NOISE_EXTRA_HYS;
         b_hys = b_hys + trig_qual_pkg::NOISE_EXTRA_HYS;
      end
      a_smp = pick(a_cfg_reg[trig_qual_pkg::ST_SRC_LSB +: 3], ch_samples, ext_sample);
      b_smp = pick(b_cfg_reg[trig_qual_pkg::ST_SRC_LSB +: 3], ch_samples, ext_sample);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         a_lvl_reg <= 1'b0;
         b_lvl_reg <= 1'b0;
         a_prev_reg <= 1'b0;
         b_prev_reg <= 1'b0;
      end else begin
         a_lvl_reg <= hys_next(a_lvl_reg, a_smp,
            a_cfg_reg[trig_qual_pkg::ST_LVL_LSB +: SMP_W], a_hys);
         b_lvl_reg <= hys_next(b_lvl_reg, b_smp,
            b_cfg_reg[trig_qual_pkg::ST_LVL_LSB +: SMP_W], b_hys);
         a_prev_reg <= a_lvl_reg;
         b_prev_reg <= b_lvl_reg;
      end
   end

   assign a_ev = edge_hit(a_prev_reg, a_lvl_reg, a_cfg_reg[trig_qual_pkg::ST_EDGE_LSB +: 2]);
   assign b_ev = edge_hit(b_prev_reg, b_lvl_reg, b_cfg_reg[trig_qual_pkg::ST_EDGE_LSB +: 2]);

   // A/B sequence
   trig_qual_pkg::seq_state_t seq_reg;
   logic [CNT_W-1:0] seq_cnt_reg;
   logic seq_fire;

   always_ff @(posedge clk) begin
      if (!rst_n || type_reg != trig_qual_pkg::TT_EDGE_AB) begin
         seq_reg <= trig_qual_pkg::SEQ_WAIT_A;
         seq_cnt_reg <= '0;
      end else if (a_ev) begin
         seq_reg <= bdly_ev_reg ? trig_qual_pkg::SEQ_WAIT_B : trig_qual_pkg::SEQ_DELAY;
         seq_cnt_reg <= '0;
      end else begin
         unique case (seq_reg)
            trig_qual_pkg::SEQ_WAIT_A: begin
            end
            trig_qual_pkg::SEQ_DELAY: begin
               seq_cnt_reg <= seq_cnt_reg + 1'b1;
               if (seq_cnt_reg + 1'b1 >= b_delay_reg) begin
                  seq_reg <= trig_qual_pkg::SEQ_WAIT_B;
               end
            end
            trig_qual_pkg::SEQ_WAIT_B: begin
               if (b_ev) begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
                  if (!bdly_ev_reg || seq_cnt_reg + 1'b1 >= b_delay_reg) begin
                     seq_reg <= trig_qual_pkg::SEQ_WAIT_A;
                  end
               end
            end
            default: seq_reg <= trig_qual_pkg::SEQ_WAIT_A;
         endcase
      end
   end

   // fire on B only after delay or on the last counted event
   assign seq_fire = seq_reg == trig_qual_pkg::SEQ_WAIT_B && b_ev
      && (!bdly_ev_reg || seq_cnt_reg + 1'b1 >= b_delay_reg);

   // Width comparator on stage A comparator
   logic [CNT_W-1:0] w_cnt_reg;
   logic w_run_reg;
   logic w_done;
   logic w_match;
   logic w_neg;

   assign w_neg = w_cfg_reg[3];
   // start on leading crossing, end on trailing crossing
   assign w_done = w_run_reg && a_prev_reg != a_lvl_reg && a_lvl_reg == w_neg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         w_cnt_reg <= '0;
         w_run_reg <= 1'b0;
         w_last_reg <= '0;
      end else if (a_prev_reg != a_lvl_reg) begin
         if (a_lvl_reg != w_neg) begin
            w_run_reg <= 1'b1;
            w_cnt_reg <= CNT_W'(1);
         end else begin
            w_run_reg <= 1'b0;
            if (w_run_reg) begin
               w_last_reg <= w_cnt_reg;
            end
         end
      end else if (w_run_reg && w_cnt_reg != '1) begin
         w_cnt_reg <= w_cnt_reg + 1'b1;
      end
   end

   always_comb begin
      unique case (w_cfg_reg[2:0])
         trig_qual_pkg::CMP_GT: w_match = w_cnt_reg > w_ref_reg;
         trig_qual_pkg::CMP_LT: w_match = w_cnt_reg < w_ref_reg;
         trig_qual_pkg::CMP_EQ: w_match = (w_tol_reg == '0) ? w_cnt_reg == w_ref_reg
            : (w_cnt_reg > w_low_reg && w_cnt_reg < w_high_reg);
         trig_qual_pkg::CMP_NE: w_match = (w_tol_reg == '0) ? w_cnt_reg != w_ref_reg
            : (w_cnt_reg < w_low_reg || w_cnt_reg > w_high_reg);
         trig_qual_pkg::CMP_IN: w_match = w_cnt_reg > w_low_reg && w_cnt_reg < w_high_reg;
         trig_qual_pkg::CMP_OUT: w_match = w_cnt_reg < w_low_reg || w_cnt_reg > w_high_reg;
         default: w_match = 1'b0;
      endcase
   end

   // Video sync: polarity opposite modulation, from stage A source
   logic v_sync;
   logic v_sync_prev_reg;
   logic [CNT_W-1:0] v_len_reg;
   logic [LW-1:0] v_line_reg;
   logic v_odd_reg;
   logic v_fire;
   logic v_start;
   logic v_end;
   logic v_frame;

   assign v_sync = a_lvl_reg ^ v_cfg_reg[7];
   assign v_start = v_sync && !v_sync_prev_reg;
   assign v_end = !v_sync && v_sync_prev_reg;
   assign v_frame = v_end && v_len_reg >= trig_qual_pkg::VSYNC_CYC;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         v_sync_prev_reg <= 1'b0;
         v_len_reg <= '0;
         v_line_reg <= trig_qual_pkg::LINE_FIRST;
         v_odd_reg <= 1'b0;
      end else begin
         v_sync_prev_reg <= v_sync;
         if (v_start) begin
            v_len_reg <= '0;
         end else if (v_sync && v_len_reg != '1) begin
            v_len_reg <= v_len_reg + 1'b1;
         end
         if (v_frame) begin
            v_line_reg <= trig_qual_pkg::LINE_FIRST;
            // progressive standards count every frame as odd
            v_odd_reg <= (v_cfg_reg[2:0] == trig_qual_pkg::VS_720P
               || v_cfg_reg[2:0] == trig_qual_pkg::VS_1080P) ? 1'b0 : !v_odd_reg;
         end else if (v_end) begin
            v_line_reg <= v_line_reg + 1'b1;
         end
      end
   end

   always_comb begin
      unique case (v_cfg_reg[5:3])
         trig_qual_pkg::VM_ALL_FRAMES: v_fire = v_frame;
         trig_qual_pkg::VM_ODD_FRAMES: v_fire = v_frame && !v_odd_reg;
         trig_qual_pkg::VM_EVEN_FRAMES: v_fire = v_frame && v_odd_reg;
         trig_qual_pkg::VM_ALL_LINES: v_fire = v_end;
         trig_qual_pkg::VM_LINE_NUM: v_fire = v_end && !v_frame
            && v_line_reg + 1'b1 == v_line_cfg_reg;
         default: v_fire = 1'b0;
      endcase
   end

   // Logic combination: per channel mask/value, AND or OR, optional min hold
   logic [NCH-1:0] ch_bits;
   logic l_true;
   logic l_prev_reg;
   logic [CNT_W-1:0] l_cnt_reg;
   logic l_fire;

   always_comb begin
      l_true = !l_cfg_reg[12];
      for (int i = 0; i < NCH; i++) begin
         ch_bits[i] = ch_samples[i*SMP_W + SMP_W - 1];
      end
      for (int i = 0; i < NCH; i++) begin
         if (l_cfg_reg[i]) begin
            if (l_cfg_reg[12]) begin
               l_true = l_true || ch_bits[i] == l_cfg_reg[4+i];
            end else begin
               l_true = l_true && ch_bits[i] == l_cfg_reg[4+i];
            end
         end
      end
      if (l_cfg_reg[12]) begin
         l_true = (l_cfg_reg[NCH-1:0] & ~(ch_bits ^ l_cfg_reg[4 +: NCH])) != '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         l_prev_reg <= 1'b0;
         l_cnt_reg <= '0;
      end else begin
         l_prev_reg <= l_true;
         l_cnt_reg <= l_true ? ((l_cnt_reg != '1) ? l_cnt_reg + 1'b1 : l_cnt_reg) : '0;
      end
   end

   // without duration fire on goes-true, else once held past time limit
   assign l_fire = l_cfg_reg[13] ? (l_true && l_cnt_reg + 1'b1 == l_time_reg)
      : (l_true && !l_prev_reg);

   // Output select
   logic fire;
   always_comb begin
      unique case (type_reg)
         trig_qual_pkg::TT_EDGE: fire = a_ev;
         trig_qual_pkg::TT_EDGE_AB: fire = seq_fire;
         trig_qual_pkg::TT_WIDTH: fire = w_done && w_match;
         trig_qual_pkg::TT_VIDEO: fire = v_fire;
         trig_qual_pkg::TT_LOGIC: fire = l_fire;
         default: fire = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trigger_pulse <= 1'b0;
         trig_count_reg <= 8'h00;
      end else begin
         trigger_pulse <= fire && arm_reg;
         if (fire && arm_reg) begin
            trig_count_reg <= trig_count_reg + 1'b1;
         end
      end
   end

   // Register reads
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         unique case (reg_addr)
            trig_qual_pkg::CTRL_OFF: reg_rdata <= 32'({arm_reg, bdly_ev_reg, hff_reg,
               noise_reg, 1'b0, type_reg});
            trig_qual_pkg::A_CFG_OFF: reg_rdata <= a_cfg_reg;
            trig_qual_pkg::B_CFG_OFF: reg_rdata <= b_cfg_reg;
            trig_qual_pkg::B_DELAY_OFF: reg_rdata <= 32'(b_delay_reg);
            trig_qual_pkg::W_CFG_OFF: reg_rdata <= 32'(w_cfg_reg);
            trig_qual_pkg::W_REF_OFF: reg_rdata <= 32'(w_ref_reg);
            trig_qual_pkg::W_TOL_OFF: reg_rdata <= 32'(w_tol_reg);
            trig_qual_pkg::W_LOW_OFF: reg_rdata <= 32'(w_low_reg);
            trig_qual_pkg::W_HIGH_OFF: reg_rdata <= 32'(w_high_reg);
            trig_qual_pkg::V_CFG_OFF: reg_rdata <= 32'(v_cfg_reg);
            trig_qual_pkg::V_LINE_OFF: reg_rdata <= 32'(v_line_cfg_reg);
            trig_qual_pkg::L_CFG_OFF: reg_rdata <= 32'(l_cfg_reg);
            trig_qual_pkg::L_TIME_OFF: reg_rdata <= 32'(l_time_reg);
            trig_qual_pkg::STATUS_OFF: reg_rdata <= 32'({trig_count_reg, 5'h00, v_odd_reg,
               seq_reg, w_run_reg, a_lvl_reg, b_lvl_reg, 1'b0, v_line_reg});
            trig_qual_pkg::W_LAST_OFF: reg_rdata <= 32'(w_last_reg);
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : trigger_qualifier_unit

/* tb/chan_src.sv */
/*
 Input channel model: registers the wanted sample levels onto the channel inputs.
 Assumes the bench sets levels just after a rising edge.
*/
`timescale 1ns/1ps
module chan_src (
   input wire logic clk,
   input wire logic [trig_qual_pkg::NCH*trig_qual_pkg::SMP_W-1:0] want_ch,
   input wire logic [trig_qual_pkg::SMP_W-1:0] want_ext,
   output logic [trig_qual_pkg::NCH*trig_qual_pkg::SMP_W-1:0] ch_samples,
   output logic [trig_qual_pkg::SMP_W-1:0] ext_sample
);
   always_ff @(posedge clk) begin
      ch_samples <= want_ch;
      ext_sample <= want_ext;
   end
endmodule : chan_src

/* tb/tb_top.sv */
/*
 Testbench: register tasks, channel stimulus and trigger pulse counting.
 Assumes the channel model and checker beside the design.
*/
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [47:0] want_ch = 48'h100_100_100_100;
   logic [11:0] want_ext = 12'h000;
   logic [47:0] ch_samples;
   logic [11:0] ext_sample;
   logic [4:0] reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic trigger_pulse;
   logic high_freq_filter_enable;
   logic [31:0] npulse = 32'h0;
   logic [31:0] base;
   logic [31:0] v;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   int exp_w[6] = '{1, 1, 0, 2, 0, 2};
   initial forever #5 clk = ~clk;
   chan_src src_u (.clk(clk), .want_ch(want_ch), .want_ext(want_ext),
      .ch_samples(ch_samples), .ext_sample(ext_sample));
   trigger_qualifier_unit dut_u (.clk(clk), .rst_n(rst_n), .ch_samples(ch_samples),
      .ext_sample(ext_sample), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .trigger_pulse(trigger_pulse), .high_freq_filter_enable(high_freq_filter_enable));
   always @(posedge clk) begin
      if (trigger_pulse === 1'b1) npulse <= npulse + 32'h1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic set_ch(input int i, input logic [11:0] s, input int hold);
      @(posedge clk);
      want_ch[i*12+:12] <= s;
      repeat (hold) @(posedge clk);
   endtask : set_ch
   task automatic pulses(input logic [31:0] exp);
      repeat (10) @(posedge clk);
      #1 check(npulse - base, exp);
      base = npulse;
   endtask : pulses
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(trig_qual_pkg::A_CFG_OFF, v);
      check({20'h0, v[27:16]}, 32'h0000_0800);
      rd(5'h1F, v);
      check(v, 32'h0000_0000);
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0030);
      #1 check({31'h0, high_freq_filter_enable}, 32'h0);
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0020);
      #1 check({31'h0, high_freq_filter_enable}, 32'h1);
      $display("test registers done");
      wr(trig_qual_pkg::A_CFG_OFF, 32'h0800_1000);
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0080);
      base = npulse;
      set_ch(0, 12'hF00, 10);
      set_ch(0, 12'h100, 0);
      pulses(32'h1);
      set_ch(0, 12'h7E0, 10);
      set_ch(0, 12'h820, 10);
      set_ch(0, 12'h7E0, 0);
      pulses(32'h1);
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0090);
      set_ch(0, 12'h820, 10);
      set_ch(0, 12'h7E0, 0);
      pulses(32'h0);
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0000);
      set_ch(0, 12'hF00, 10);
      set_ch(0, 12'h100, 0);
      pulses(32'h0);
      $display("test edge done");
      wr(trig_qual_pkg::B_CFG_OFF, 32'h0800_1001);
      wr(trig_qual_pkg::B_DELAY_OFF, 32'h0000_0003);
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_00C1);
      for (int k = 0; k < 2; k++) begin
         set_ch(1, 12'hF00, 10);
         set_ch(1, 12'h100, 10);
      end
      set_ch(0, 12'hF00, 10);
      pulses(32'h0);
      for (int k = 0; k < 2; k++) begin
         set_ch(1, 12'hF00, 10);
         set_ch(1, 12'h100, 10);
      end
      pulses(32'h0);
      set_ch(1, 12'hF00, 10);
      set_ch(1, 12'h100, 0);
      pulses(32'h1);
      set_ch(0, 12'h100, 10);
      $display("test sequence done");
      wr(trig_qual_pkg::W_LOW_OFF, 32'h0000_0028);
      wr(trig_qual_pkg::W_HIGH_OFF, 32'h0000_003C);
      rd(trig_qual_pkg::W_REF_OFF, v);
      check(v, 32'h0000_0032);
      rd(trig_qual_pkg::W_TOL_OFF, v);
      check(v, 32'h0000_000A);
      wr(trig_qual_pkg::W_REF_OFF, 32'h0000_0014);
      wr(trig_qual_pkg::W_TOL_OFF, 32'h0000_0005);
      rd(trig_qual_pkg::W_LOW_OFF, v);
      check(v, 32'h0000_000F);
      rd(trig_qual_pkg::W_HIGH_OFF, v);
      check(v, 32'h0000_0019);
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0082);
      for (int m = 0; m < 6; m++) begin
         wr(trig_qual_pkg::W_CFG_OFF, 32'(m));
         base = npulse;
         set_ch(0, 12'hF00, 9);
         set_ch(0, 12'h100, 10);
         set_ch(0, 12'hF00, 29);
         set_ch(0, 12'h100, 0);
         pulses(32'(exp_w[m]));
      end
      wr(trig_qual_pkg::W_CFG_OFF, 32'h0000_0008);
      set_ch(0, 12'hF00, 10);
      set_ch(0, 12'h100, 29);
      set_ch(0, 12'hF00, 0);
      pulses(32'h1);
      $display("test width done");
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0083);
      wr(trig_qual_pkg::V_CFG_OFF, 32'h0000_0018);
      set_ch(0, 12'h100, 10);
      pulses(32'h1);
      wr(trig_qual_pkg::V_CFG_OFF, 32'h0000_0080);
      set_ch(0, 12'h100, 1000);
      set_ch(0, 12'hF00, 0);
      pulses(32'h1);
      $display("test video done");
      wr(trig_qual_pkg::CTRL_OFF, 32'h0000_0084);
      wr(trig_qual_pkg::L_CFG_OFF, 32'h0000_0011);
      set_ch(0, 12'h100, 10);
      set_ch(0, 12'hF00, 0);
      pulses(32'h1);
      $display("test logic done");
      print_verdict();
   end
endmodule : tb_top
bind trigger_qualifier_unit trig_qual_sva chk_u (.clk(clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .trigger_pulse(trigger_pulse),
   .high_freq_filter_enable(high_freq_filter_enable));

/* tb/trig_qual_sva.sv */
/*
 Checker for the trigger qualifier top ports.
 Assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module trig_qual_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [trig_qual_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic trigger_pulse,
   input wire logic high_freq_filter_enable
);
   logic [7:0] ctrl_reg;
   logic wr_ctrl;
   assign wr_ctrl = reg_write && (reg_addr == trig_qual_pkg::CTRL_OFF);
   always_ff @(posedge clk) begin
      if (!rst_n) ctrl_reg <= 8'h00;
      else if (wr_ctrl) ctrl_reg <= reg_wdata[7:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_hff_follows_ctrl: assert property (wr_ctrl |=> high_freq_filter_enable ==
      ($past(reg_wdata[5]) && !$past(reg_wdata[4]))) else $error("filter enable wrong");
   a_hff_holds_level: assert property (!wr_ctrl |=> $stable(high_freq_filter_enable))
      else $error("filter enable moved");
   a_filter_excludes_noise: assert property (high_freq_filter_enable |-> !ctrl_reg[4])
      else $error("filter and noise reject both on");
   a_pulse_needs_arm: assert property (trigger_pulse |-> ctrl_reg[7] || $past(ctrl_reg[7]))
      else $error("trigger while disarmed");
   a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (reg_read && reg_addr > trig_qual_pkg::V_LINE_OFF
      |=> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_ctrl_readback: assert property (reg_read && reg_addr == trig_qual_pkg::CTRL_OFF
      |=> reg_rdata[7:6] == ctrl_reg[7:6] && reg_rdata[2:0] == ctrl_reg[2:0])
      else $error("control readback wrong");
   a_reset_quiet: assert property ($rose(rst_n) |-> reg_rdata == 32'h0000_0000
      && !trigger_pulse && !high_freq_filter_enable) else $error("outputs not cleared");
endmodule : trig_qual_sva
